// ===== design/uwf_pkg.sv
// Shared constants for the flow-controlled serial transmitter and receiver.
package uwf_pkg;

  // ****************************************************************
  // Clock and bit timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned MIN_BIT_NS    = 1000;
  localparam logic [15:0] MIN_DIV =
    16'((MIN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] DIV_RESET     = 16'h00d9;

  // ****************************************************************
  // Frame layout and buffering
  // ****************************************************************
  localparam int unsigned DATA_BITS     = 8;
  localparam logic [2:0]  LAST_BIT      = 3'h7;
  localparam int unsigned RX_FIFO_DEPTH = 4;
  localparam logic        FLOW_RESET    = 1'h0;
  localparam logic        PARITY_RESET  = 1'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP
  } uwf_state_t;

endpackage : uwf_pkg

// ===== design/uwf_fifo_if.sv
// Valid/ready carrier between the receiver and its buffer.
`timescale 1ns/1ps
interface uwf_fifo_if #(parameter int WIDTH = 8);
  logic             wValid;
  logic             wReady;
  logic [WIDTH-1:0] wData;
  logic             rValid;
  logic             rReady;
  logic [WIDTH-1:0] rData;
  modport src  (output wValid, output wData, input wReady);
  modport fifo (input wValid, input wData, output wReady,
                output rValid, output rData, input rReady);
  modport snk  (input rValid, input rData, output rReady);
endinterface : uwf_fifo_if

// ===== design/uwf_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module uwf_fifo
  import uwf_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Buffer ports
  uwf_fifo_if.fifo  port
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             doPush;
  logic             doPop;

  assign port.wReady = (count_ff != (AW+1)'(DEPTH));
  assign port.rValid = (count_ff != '0);
  assign port.rData  = mem[rdPtr_ff];
  assign doPush      = port.wValid && port.wReady;
  assign doPop       = port.rValid && port.rReady;

  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      mem[wrPtr_ff] <= port.wData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (doPop) begin
        rdPtr_ff <= (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + 1'b1;
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule : uwf_fifo

// ===== design/uwf_uart.sv
// Serial transmitter and receiver with request/clear-to-send flow control.
// What this block does
// - Programmable bit divider, fastest rate 1 Mbps.
// - Transmit and receive lines, optional RTS/CTS.
// - Flow control selectable, disabled after reset.
// - RTS off whenever reception cannot proceed.
// - Eight data bits, optional even parity, one stop.
// - Reset frame format is eight, none, one.
// - Data bits go least significant first.
`timescale 1ns/1ps
module uwf_uart
  import uwf_pkg::*;
#(
  parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Configuration; baudDiv, flowEn and parityEn taken while both directions are idle
  input  wire logic [15:0] baudDiv,
  input  wire logic        flowEn,
  input  wire logic        parityEn,
  input  wire logic        powerSave,
  // Transmit byte stream
  input  wire logic [7:0]  txData,
  input  wire logic        txValid,
  output logic             txReady_ff,
  // Receive byte stream
  output logic [7:0]       rxData_ff,
  output logic             rxValid_ff,
  input  wire logic        rxReady,
  output logic             rxParityErr_ff,
  output logic             rxFrameErr_ff,
  output logic             rxOverrun_ff,
  // Serial pins
  output logic             txd_ff,
  input  wire logic        rxd,
  output logic             rtsN_ff,
  input  wire logic        ctsN
);

  // ****************************************************************
  // Configuration and pin synchronisers
  // ****************************************************************
  logic [15:0] div_ff;
  logic        flowEn_ff;
  logic        parityEn_ff;
  logic [2:0]  rxSync_ff;
  logic [2:0]  ctsSync_ff;
  logic        rxLevel_ff;
  logic        ctsOn_ff;
  uwf_state_t  txState_ff;
  uwf_state_t  rxState_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_ff      <= DIV_RESET;
      flowEn_ff   <= FLOW_RESET;
      parityEn_ff <= PARITY_RESET;
    end else if (txState_ff == ST_IDLE && rxState_ff == ST_IDLE) begin
      div_ff      <= (baudDiv < MIN_DIV) ? MIN_DIV : baudDiv;
      flowEn_ff   <= flowEn;
      parityEn_ff <= parityEn;
    end
  end

  // A line level changes only once the second and third stages agree.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rxSync_ff  <= 3'h7;
      ctsSync_ff <= 3'h7;
      rxLevel_ff <= 1'h1;
      ctsOn_ff   <= 1'h0;
    end else begin
      rxSync_ff  <= {rxSync_ff[1:0], rxd};
      ctsSync_ff <= {ctsSync_ff[1:0], ctsN};
      if (rxSync_ff[1] == rxSync_ff[2]) begin
        rxLevel_ff <= rxSync_ff[2];
      end
      if (ctsSync_ff[1] == ctsSync_ff[2]) begin
        ctsOn_ff <= !ctsSync_ff[2];
      end
    end
  end

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  logic [15:0] txCnt_ff;
  logic [2:0]  txIdx_ff;
  logic [7:0]  txByte_ff;
  logic        txTick;
  logic        txGo;
  logic        txAccept;

  assign txTick   = (txCnt_ff == div_ff - 16'h0001);
  assign txGo     = !flowEn_ff || ctsOn_ff;
  assign txAccept = txValid && txReady_ff && txGo;

  always_ff @(posedge ref_clk) begin
    if (!rst_n || txState_ff == ST_IDLE || txTick) begin
      txCnt_ff <= '0;
    end else begin
      txCnt_ff <= txCnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      txState_ff <= ST_IDLE;
      txd_ff     <= 1'h1;
      txIdx_ff   <= '0;
      txByte_ff  <= '0;
      txReady_ff <= 1'h0;
    end else begin
      case (txState_ff)
        ST_IDLE: begin
          txReady_ff <= txGo && !txAccept;
          if (txAccept) begin
            txByte_ff  <= txData;
            txd_ff     <= 1'h0;
            txState_ff <= ST_START;
          end
        end
        ST_START: begin
          if (txTick) begin
            txIdx_ff   <= '0;
            txd_ff     <= txByte_ff[0];
            txState_ff <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (txTick && txIdx_ff == LAST_BIT) begin
            if (parityEn_ff) begin
              txd_ff     <= ^txByte_ff;
              txState_ff <= ST_PARITY;
            end else begin
              txd_ff     <= 1'h1;
              txState_ff <= ST_STOP;
            end
          end else if (txTick) begin
            txIdx_ff <= txIdx_ff + 3'h1;
            txd_ff   <= txByte_ff[txIdx_ff + 3'h1];
          end
        end
        ST_PARITY: begin
          if (txTick) begin
            txd_ff     <= 1'h1;
            txState_ff <= ST_STOP;
          end
        end
        default: begin
          if (txTick) begin
            txState_ff <= ST_IDLE;
            txReady_ff <= txGo;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Receiver
  // ****************************************************************
  uwf_fifo_if #(.WIDTH(DATA_BITS)) rxq ();

  logic [15:0] rxCnt_ff;
  logic [2:0]  rxIdx_ff;
  logic [7:0]  rxByte_ff;
  logic        rxParOk_ff;
  logic        rxPush_ff;
  logic        rxTick;
  logic        rxHalf;

  assign rxTick = (rxCnt_ff == div_ff - 16'h0001);
  assign rxHalf = (rxCnt_ff == {1'b0, div_ff[15:1]});

  always_ff @(posedge ref_clk) begin
    if (!rst_n || rxState_ff == ST_IDLE || rxTick
        || (rxState_ff == ST_START && rxHalf)) begin
      rxCnt_ff <= '0;
    end else begin
      rxCnt_ff <= rxCnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rxState_ff     <= ST_IDLE;
      rxIdx_ff       <= '0;
      rxByte_ff      <= '0;
      rxParOk_ff     <= 1'h1;
      rxPush_ff      <= 1'h0;
      rxParityErr_ff <= 1'h0;
      rxFrameErr_ff  <= 1'h0;
      rxOverrun_ff   <= 1'h0;
    end else begin
      rxPush_ff      <= 1'h0;
      rxParityErr_ff <= 1'h0;
      rxFrameErr_ff  <= 1'h0;
      rxOverrun_ff   <= 1'h0;
      case (rxState_ff)
        ST_IDLE: begin
          if (!rxLevel_ff) begin
            rxState_ff <= ST_START;
          end
        end
        ST_START: begin
          if (rxHalf) begin
            rxIdx_ff   <= '0;
            rxParOk_ff <= 1'h1;
            rxState_ff <= rxLevel_ff ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rxTick) begin
            rxByte_ff[rxIdx_ff] <= rxLevel_ff;
            rxIdx_ff            <= rxIdx_ff + 3'h1;
            if (rxIdx_ff == LAST_BIT) begin
              rxState_ff <= parityEn_ff ? ST_PARITY : ST_STOP;
            end
          end
        end
        ST_PARITY: begin
          if (rxTick) begin
            rxParOk_ff <= (^rxByte_ff) == rxLevel_ff;
            rxState_ff <= ST_STOP;
          end
        end
        default: begin
          if (rxTick) begin
            rxState_ff     <= ST_IDLE;
            rxFrameErr_ff  <= !rxLevel_ff;
            rxParityErr_ff <= !rxParOk_ff;
            rxOverrun_ff   <= rxLevel_ff && rxParOk_ff && !rxq.wReady;
            rxPush_ff      <= rxLevel_ff && rxParOk_ff && rxq.wReady;
          end
        end
      endcase
    end
  end

  assign rxq.wValid = rxPush_ff;
  assign rxq.wData  = rxByte_ff;

  uwf_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_rxFifo (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .port    (rxq)
  );

  assign rxq.rReady = !rxValid_ff || rxReady;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rxValid_ff <= 1'h0;
      rxData_ff  <= '0;
    end else if (rxq.rReady) begin
      rxValid_ff <= rxq.rValid;
      rxData_ff  <= rxq.rData;
    end
  end

  // RTS is low (on) only while a byte can be stored and not power saving.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rtsN_ff <= 1'h1;
    end else begin
      rtsN_ff <= powerSave || !rxq.wReady || rxPush_ff;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_startBit;
    (txState_ff == ST_START && !txd_ff && !txReady_ff);
  endsequence
  sequence s_startEnd;
    (txState_ff == ST_START && txTick);
  endsequence
  sequence s_dataLsb;
    (txState_ff == ST_DATA && txIdx_ff == 3'h0
     && txd_ff == txByte_ff[0]);
  endsequence

  property p_divFloor;
    div_ff >= MIN_DIV;
  endproperty
  a_divFloor: assert property (p_divFloor)
    else $error("bit divider below fastest rate");

  property p_idleHigh;
    txState_ff == ST_IDLE |-> txd_ff;
  endproperty
  a_idleHigh: assert property (p_idleHigh)
    else $error("transmit line not high while idle");

  property p_resetCfg;
    $rose(rst_n) |-> !flowEn_ff && !parityEn_ff && div_ff == DIV_RESET;
  endproperty
  a_resetCfg: assert property (p_resetCfg)
    else $error("configuration not at reset defaults");

  property p_rtsOff;
    (powerSave || !rxq.wReady) |=> rtsN_ff;
  endproperty
  a_rtsOff: assert property (p_rtsOff)
    else $error("RTS on while unable to accept");

  property p_parityBit;
    txState_ff == ST_PARITY |-> parityEn_ff && txd_ff == ^txByte_ff;
  endproperty
  a_parityBit: assert property (p_parityBit)
    else $error("wrong or unexpected parity bit");

  property p_stopBit;
    txState_ff == ST_STOP |-> txd_ff;
  endproperty
  a_stopBit: assert property (p_stopBit)
    else $error("stop bit not high");

  property p_noParity;
    (txState_ff == ST_DATA && txTick && txIdx_ff == LAST_BIT
     && !parityEn_ff) |=> txState_ff == ST_STOP;
  endproperty
  a_noParity: assert property (p_noParity)
    else $error("parity bit sent while disabled");

  property p_startBit;
    txAccept |=> s_startBit;
  endproperty
  a_startBit: assert property (p_startBit)
    else $error("no start bit after a byte was taken");

  // The first data bit replaces the start bit on the tick that ends it.
  property p_lsbFirst;
    s_startEnd |=> s_dataLsb;
  endproperty
  a_lsbFirst: assert property (p_lsbFirst)
    else $error("first data bit is not the LSB");

  property p_dataOrder;
    txState_ff == ST_DATA |-> txd_ff == txByte_ff[txIdx_ff];
  endproperty
  a_dataOrder: assert property (p_dataOrder)
    else $error("data bit out of order");

  property p_ctsHold;
    (flowEn_ff && !ctsOn_ff && txState_ff == ST_IDLE)
      |=> txState_ff == ST_IDLE;
  endproperty
  a_ctsHold: assert property (p_ctsHold)
    else $error("frame started while CTS off");

endmodule : uwf_uart

// ===== tb/uwf_far_uart.sv
// Far-side serial device: sends frames to rxd and collects frames from txd.
`timescale 1ns/1ps
module uwf_far_uart (
  // Clock and line setup
  input  wire logic        ref_clk,
  input  wire logic [15:0] bitDiv,
  input  wire logic        parOn,
  // Serial lines
  input  wire logic        txd,
  output logic             rxd
);
  logic [9:0] gotQ[$];
  logic [9:0] w;

  initial rxd = 1'b1;

  // A bad stop bit is cut short so that the idle level is back before
  // the receiver looks for the next start bit.
  task automatic send(input logic [7:0] d, input logic badPar,
                      input logic badStop);
    logic [10:0] f;
    int          n;
    f = parOn ? {~badStop, ^d ^ badPar, d, 1'b0}
              : {1'b1, ~badStop, d, 1'b0};
    n = parOn ? 11 : 10;
    @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat ((i == n - 1 && badStop) ? bitDiv / 2 + 5 : bitDiv)
        @(posedge ref_clk);
    end
    rxd <= 1'b1;
    repeat (bitDiv) @(posedge ref_clk);
  endtask : send

  // Samples each bit in its middle and stores {stop, parity, data}.
  always begin
    @(posedge ref_clk iff txd === 1'b0);
    repeat (bitDiv / 2) @(posedge ref_clk);
    for (int i = 0; i < (parOn ? 10 : 9); i++) begin
      repeat (bitDiv) @(posedge ref_clk);
      w[i] = txd;
    end
    if (!parOn) begin
      w = {w[8], 1'b0, w[7:0]};
    end
    gotQ.push_back(w);
  end
endmodule : uwf_far_uart

// ===== tb/testbench.sv
// Self-checking bench for the flow-controlled serial block.
`timescale 1ns/1ps
module testbench
  import uwf_pkg::*;
;
  logic        ref_clk, rst_n, flowEn, parityEn, powerSave;
  logic        txValid, rxReady, ctsN, rxd;
  logic [15:0] baudDiv, farDiv;
  logic [7:0]  txData, rxData_ff, d;
  logic        txReady_ff, rxValid_ff, txd_ff, rtsN_ff;
  logic        rxParityErr_ff, rxFrameErr_ff, rxOverrun_ff;
  logic [9:0]  w;
  logic [7:0]  bq[5];
  logic [31:0] seed = 32'h5cb0;
  int          err_count, cmp_count, cycles, nPar, nFrm, nOvr, lowCnt, k;

  uwf_uart uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .baudDiv(baudDiv),
    .flowEn(flowEn), .parityEn(parityEn), .powerSave(powerSave),
    .txData(txData), .txValid(txValid), .txReady_ff(txReady_ff),
    .rxData_ff(rxData_ff), .rxValid_ff(rxValid_ff), .rxReady(rxReady),
    .rxParityErr_ff(rxParityErr_ff), .rxFrameErr_ff(rxFrameErr_ff),
    .rxOverrun_ff(rxOverrun_ff), .txd_ff(txd_ff), .rxd(rxd),
    .rtsN_ff(rtsN_ff), .ctsN(ctsN));

  uwf_far_uart far (.ref_clk(ref_clk), .bitDiv(farDiv),
    .parOn(parityEn), .txd(txd_ff), .rxd(rxd));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (rxParityErr_ff === 1'b1) nPar++;
    if (rxFrameErr_ff === 1'b1) nFrm++;
    if (rxOverrun_ff === 1'b1) nOvr++;
    if (cycles == 40000) begin
      err_count++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Expected frame as {stop, parity or zero, data}.
  function automatic logic [9:0] exp_frame(input logic [7:0] b,
                                           input logic       par);
    return {1'b1, par & ^b, b};
  endfunction : exp_frame

  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag

  task automatic tx_frame(input logic [7:0] b);
    @(posedge ref_clk);
    txData  <= b;
    txValid <= 1'b1;
    @(posedge ref_clk iff txReady_ff === 1'b1);
    txValid <= 1'b0;
    while (far.gotQ.size() == 0) @(posedge ref_clk);
    w = far.gotQ.pop_front();
    chk_val(w, exp_frame(b, parityEn));
  endtask : tx_frame

  task automatic get_rx(input logic [7:0] b);
    @(negedge ref_clk iff rxValid_ff === 1'b1);
    chk_val({2'h0, rxData_ff}, {2'h0, b});
    @(posedge ref_clk);
    rxReady <= 1'b1;
    @(posedge ref_clk);
    rxReady <= 1'b0;
  endtask : get_rx

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n     = 1'b0;
    baudDiv   = 16'h000a;
    farDiv    = MIN_DIV;
    flowEn    = 1'b0;
    parityEn  = 1'b0;
    powerSave = 1'b0;
    txData    = 8'h00;
    txValid   = 1'b0;
    rxReady   = 1'b0;
    ctsN      = 1'b1;
    repeat (6) @(posedge ref_clk);
    chk_flag(txd_ff, 1'b1);
    chk_flag(rtsN_ff, 1'b1);
    rst_n <= 1'b1;
    // An inactive CTS must not block while flow control is off.
    tx_frame(8'h01);
    for (k = 0; k < 6; k++) tx_frame(8'(xs()));
    for (k = 0; k < 6; k++) begin
      d = 8'(xs());
      far.send(d, 1'b0, 1'b0);
      get_rx(d);
    end
    $display("test plain frames finished");
    @(posedge ref_clk);
    parityEn <= 1'b1;
    for (k = 0; k < 4; k++) tx_frame(8'(xs()));
    d = 8'(xs());
    far.send(d, 1'b0, 1'b0);
    get_rx(d);
    k = nPar;
    far.send(d, 1'b1, 1'b0);
    repeat (4) @(negedge ref_clk);
    chk_val(10'(nPar - k), 10'h001);
    chk_flag(rxValid_ff, 1'b0);
    k = nFrm;
    far.send(d, 1'b0, 1'b1);
    repeat (4) @(negedge ref_clk);
    chk_val(10'(nFrm - k), 10'h001);
    $display("test parity and stop finished");
    @(posedge ref_clk);
    parityEn <= 1'b0;
    for (k = 0; k < 5; k++) begin
      bq[k] = 8'(xs());
      far.send(bq[k], 1'b0, 1'b0);
    end
    repeat (3) @(negedge ref_clk);
    chk_flag(rtsN_ff, 1'b1);
    k = nOvr;
    far.send(8'h5a, 1'b0, 1'b0);
    repeat (4) @(negedge ref_clk);
    chk_val(10'(nOvr - k), 10'h001);
    for (k = 0; k < 5; k++) get_rx(bq[k]);
    repeat (4) @(negedge ref_clk);
    chk_flag(rtsN_ff, 1'b0);
    @(posedge ref_clk);
    powerSave <= 1'b1;
    repeat (3) @(negedge ref_clk);
    chk_flag(rtsN_ff, 1'b1);
    @(posedge ref_clk);
    powerSave <= 1'b0;
    $display("test request to send finished");
    flowEn <= 1'b1;
    repeat (10) @(negedge ref_clk);
    chk_flag(txReady_ff, 1'b0);
    lowCnt = 0;
    fork
      tx_frame(8'ha5);
      begin
        repeat (100) @(negedge ref_clk) if (txd_ff !== 1'b1) lowCnt++;
        @(posedge ref_clk);
        ctsN <= 1'b0;
      end
    join
    chk_val(10'(lowCnt), 10'h000);
    tx_frame(8'(xs()));
    $display("test clear to send finished");
    // The divider is only taken while both directions are idle, so the
    // stop bit of the last frame has to end first.
    repeat (30) @(posedge ref_clk);
    baudDiv <= 16'h0030;
    farDiv  <= 16'h0030;
    tx_frame(8'(xs()));
    d = 8'(xs());
    far.send(d, 1'b0, 1'b0);
    get_rx(d);
    $display("test slower rate finished");
    end_of_test();
  end
endmodule : testbench
